//--- rtl/ext_irq_unit.sv
// The implementer's own choices: the APB register port and the placing of the registers.
module ext_irq_unit #(
  parameter int unsigned STARTUP_CYC = ext_irq_pkg::STARTUP_CYC_DEF
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // register bus
  input  wire ext_irq_pkg::apb_req_t apb_req,
  output ext_irq_pkg::apb_rsp_t     apb_rsp,
  // pads: bit0 line a, bit1 line b, bit2 line c
  input  wire logic [2:0]           irq_pin,
  // handler entry, one pulse per line
  input  wire logic [2:0]           irq_ack,
  // interrupt and power status
  output logic                      irq,
  output logic [2:0]                irq_pending,
  output logic                      asleep,
  output logic                      io_clk_run,
  output logic                      wake
);
  import ext_irq_pkg::*;

  // register view {b,a,c} at bits 7..5 against internal {c,b,a}
  function automatic logic [2:0] from_reg(input logic [31:0] w);
    from_reg = {w[LINE_C_BIT], w[LINE_B_BIT], w[LINE_A_BIT]};
  endfunction

  function automatic logic [31:0] to_reg(input logic [2:0] v);
    logic [31:0] w;
    w = 32'h0;
    w[LINE_A_BIT] = v[0];
    w[LINE_B_BIT] = v[1];
    w[LINE_C_BIT] = v[2];
    to_reg = w;
  endfunction

  // edge decode for lines a and b, one sample against the next
  function automatic logic edge_hit(input sense_t s, input logic prev, input logic cur);
    unique case (s)
      SENSE_ANY:  edge_hit = prev ^ cur;
      SENSE_FALL: edge_hit = prev & ~cur;
      SENSE_RISE: edge_hit = ~prev & cur;
      SENSE_LOW:  edge_hit = 1'b0;
    endcase
  endfunction

  logic [2:0]  pin_s1_ff;
  logic [2:0]  pin_s2_ff;
  logic [1:0]  ab_prev_ff;
  logic        c_prev_ff;
  sense_t      sense_a_ff;
  sense_t      sense_b_ff;
  logic        pol_c_ff;
  logic [2:0]  en_ff;
  logic        glob_ff;
  logic [2:0]  flag_ff;
  sleep_mode_t mode_ff;
  wake_state_t state_ff;
  wake_state_t nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [31:0] prdata_ff;
  logic        wake_ff;
  logic [2:0]  nxt_flag;
  logic [7:0]  qual_len_ff;

  // bus decode
  wire       setup_ph  = apb_req.psel & ~apb_req.penable;
  wire       access_ph = apb_req.psel & apb_req.penable;
  wire       wr        = access_ph & apb_req.pwrite;
  wire       hit_ctrl  = apb_req.paddr == OFS_CTRL;
  wire       hit_csr   = apb_req.paddr == OFS_CSR;
  wire       hit_en    = apb_req.paddr == OFS_ENABLE;
  wire       hit_flag  = apb_req.paddr == OFS_FLAG;
  wire       hit_stat  = apb_req.paddr == OFS_STATUS;
  wire       hit_sleep = apb_req.paddr == OFS_SLEEP;
  wire       mapped    = hit_ctrl | hit_csr | hit_en | hit_flag | hit_stat | hit_sleep;
  wire [2:0] wr_lines  = from_reg(apb_req.pwdata);

  // read mux; sampled in setup so prdata is a flop and no wait state is needed
  wire [31:0] rd_ctrl  = {28'h0, sense_b_ff, sense_a_ff};
  wire [31:0] rd_csr   = {25'h0, pol_c_ff, 6'h0};
  wire [31:0] rd_stat  = {24'h0, glob_ff, 7'h0};
  wire [31:0] rd_sleep = {21'h0, state_ff, 1'b0, pin_s2_ff, 1'b0, mode_ff, asleep};
  wire [31:0] rd_word  = hit_ctrl  ? rd_ctrl :
                         hit_csr   ? rd_csr :
                         hit_en    ? to_reg(en_ff) :
                         hit_flag  ? to_reg(flag_ff) :
                         hit_stat  ? rd_stat :
                         hit_sleep ? rd_sleep : 32'h0;

  assign apb_rsp.prdata  = prdata_ff;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access_ph & ~mapped;

  // detection; the pad is read whatever its direction, so a driven pin
  // triggers its own line and serves as a software interrupt
  wire       io_run    = (state_ff == ST_AWAKE) | (mode_ff == MODE_IDLE);
  wire [1:0] lvl_mode  = {sense_b_ff == SENSE_LOW, sense_a_ff == SENSE_LOW};
  wire [1:0] lvl_raw   = lvl_mode & ~pin_s2_ff[1:0];
  wire       lvl_block = (state_ff != ST_AWAKE) & (state_ff != ST_SLEEPING);
  wire [1:0] lvl_req   = lvl_raw & {2{~lvl_block}};
  wire       edge_a    = io_run & edge_hit(sense_a_ff, ab_prev_ff[0], pin_s2_ff[0]);
  wire       edge_b    = io_run & edge_hit(sense_b_ff, ab_prev_ff[1], pin_s2_ff[1]);
  wire       c_lvl     = pol_c_ff ? pin_s2_ff[2] : ~pin_s2_ff[2];
  wire       edge_c    = c_lvl & ~c_prev_ff;
  wire [2:0] events    = {edge_c, edge_b, edge_a};
  wire [2:0] armed     = en_ff & {3{glob_ff}};
  wire [2:0] flag_clr  = irq_ack | ({3{wr & hit_flag}} & wr_lines);
  wire       wake_edge = |(events & armed);
  wire       lvl_wake  = |(lvl_raw & armed[1:0]);
  wire       cnt_done  = cnt_ff == 16'h0;

  // flags: a same-cycle event beats the clear; level mode pins the flag low
  always_comb
  begin
    nxt_flag = (flag_ff & ~flag_clr) | events;
    nxt_flag[1:0] = nxt_flag[1:0] & ~lvl_mode;
  end

  assign irq_pending = armed & (flag_ff | {1'b0, lvl_req});
  assign irq         = |irq_pending;
  assign asleep      = state_ff != ST_AWAKE;
  assign io_clk_run  = io_run;
  assign wake        = wake_ff;

  // wake sequencer; power-down level wake is qualified by two samples
  // one watchdog period apart, then waits the start-up delay
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff - 16'h1;
    unique case (state_ff)
      ST_AWAKE:
      begin
        nxt_cnt = 16'h0;
        if (wr & hit_sleep & apb_req.pwdata[SLEEP_GO_BIT])
          nxt_state = ST_SLEEPING;
      end
      ST_SLEEPING:
      begin
        nxt_cnt = 16'(WDT_CYC - 1);
        if (wake_edge)
          nxt_state = ST_AWAKE;
        else if (lvl_wake)
          nxt_state = (mode_ff == MODE_POWER_DOWN) ? ST_QUAL1 : ST_AWAKE;
      end
      ST_QUAL1, ST_QUAL2:
      begin
        if (wake_edge)
          nxt_state = ST_AWAKE;
        else if (cnt_done & ~lvl_wake)
          nxt_state = ST_SLEEPING;
        else if (cnt_done)
        begin
          nxt_state = (state_ff == ST_QUAL1) ? ST_QUAL2 : ST_STARTUP;
          nxt_cnt   = (state_ff == ST_QUAL1) ? 16'(WDT_CYC - 1) : 16'(STARTUP_CYC - 1);
        end
      end
      ST_STARTUP:
      begin
        if (cnt_done)
          nxt_state = ST_AWAKE;
      end
      default:
      begin
        nxt_state = ST_AWAKE;
        nxt_cnt   = 16'h0;
      end
    endcase
  end

  // pad synchroniser; stage one feeds stage two only
  always_ff @(posedge sys_clk)
  begin
    pin_s1_ff <= irq_pin;
    pin_s2_ff <= pin_s1_ff;
  end

  // previous samples; a/b history keeps tracking the pad in deep sleep, so an
  // edge that came while the io clock was off is not seen late after wake
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ab_prev_ff <= 2'h3;
      c_prev_ff  <= 1'b0;
    end
    else
    begin
      ab_prev_ff <= pin_s2_ff[1:0];
      c_prev_ff <= c_lvl;
    end
  end

  // software registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sense_a_ff <= sense_t'(SENSE_RST);
      sense_b_ff <= sense_t'(SENSE_RST);
      pol_c_ff   <= 1'b0;
      en_ff      <= LINES_RST;
      glob_ff    <= 1'b0;
      mode_ff    <= MODE_IDLE;
    end
    else if (wr)
    begin
      if (hit_ctrl)
      begin
        sense_a_ff <= sense_t'(apb_req.pwdata[SENSE_A_LSB +: 2]);
        sense_b_ff <= sense_t'(apb_req.pwdata[SENSE_B_LSB +: 2]);
      end
      if (hit_csr)
        pol_c_ff <= apb_req.pwdata[POL_C_BIT];
      if (hit_en)
        en_ff <= wr_lines;
      if (hit_stat)
        glob_ff <= apb_req.pwdata[GLOBAL_BIT];
      if (hit_sleep)
        mode_ff <= sleep_mode_t'(apb_req.pwdata[SLEEP_MODE_LSB +: 2]);
    end
  end

  // flags, sequencer and read data
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      flag_ff   <= LINES_RST;
      state_ff  <= ST_AWAKE;
      cnt_ff    <= 16'h0;
      wake_ff   <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      flag_ff  <= nxt_flag;
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      wake_ff  <= (state_ff != ST_AWAKE) & (nxt_state == ST_AWAKE);
      if (setup_ph)
        prdata_ff <= rd_word;
    end
  end

  // cycles spent in the current state; only read in the qualification states
  always_ff @(posedge sys_clk)
  begin
    if (reset | (nxt_state != state_ff))
      qual_len_ff <= 8'h0;
    else
      qual_len_ff <= qual_len_ff + 8'h1;
  end

  // checks
  property p_flag_set;
    @(posedge sys_clk) disable iff (reset)
    (edge_a & (sense_a_ff != SENSE_LOW)) |=> flag_ff[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge did not set flag a");

  property p_lvl_flag_zero;
    @(posedge sys_clk) disable iff (reset)
    (sense_b_ff == SENSE_LOW) [*2] |-> !flag_ff[1];
  endproperty
  a_lvl_flag_zero: assert property (p_lvl_flag_zero) else $error("flag b set in level mode");

  property p_lvl_hold;
    @(posedge sys_clk) disable iff (reset)
    (armed[0] & lvl_mode[0] & !pin_s2_ff[0] & (state_ff == ST_AWAKE)) |-> irq;
  endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("low level not requesting");

  property p_need_global;
    @(posedge sys_clk) disable iff (reset)
    irq |-> glob_ff && (|(en_ff & (flag_ff | {1'b0, lvl_raw})));
  endproperty
  a_need_global: assert property (p_need_global) else $error("irq without enables");

  property p_edge_needs_io;
    @(posedge sys_clk) disable iff (reset)
    $rose(flag_ff[0]) |-> $past(io_run);
  endproperty
  a_edge_needs_io: assert property (p_edge_needs_io) else $error("flag a set, io clock off");

  property p_io_stop;
    @(posedge sys_clk) disable iff (reset)
    (state_ff == ST_SLEEPING && mode_ff != MODE_IDLE) |-> !io_clk_run;
  endproperty
  a_io_stop: assert property (p_io_stop) else $error("io clock runs in deep sleep");

  property p_qual_len;
    @(posedge sys_clk) disable iff (reset)
    ((state_ff == ST_QUAL1 || state_ff == ST_QUAL2) && nxt_state != state_ff &&
     nxt_state != ST_AWAKE) |-> qual_len_ff == 8'(WDT_CYC - 1);
  endproperty
  a_qual_len: assert property (p_qual_len) else $error("level sample came early");

  property p_startup_entry;
    @(posedge sys_clk) disable iff (reset)
    $rose(state_ff == ST_STARTUP) |-> $past(state_ff) == ST_QUAL2 && $past(lvl_wake);
  endproperty
  a_startup_entry: assert property (p_startup_entry) else $error("start-up without samples");

  property p_no_late_lvl;
    @(posedge sys_clk) disable iff (reset)
    (state_ff == ST_STARTUP && cnt_done && pin_s2_ff[0] && pin_s1_ff[0] && irq_pin[0])
      |=> !lvl_req[0] ##1 (state_ff == ST_AWAKE);
  endproperty
  a_no_late_lvl: assert property (p_no_late_lvl) else $error("late level request");

  property p_c_wake;
    @(posedge sys_clk) disable iff (reset)
    (state_ff == ST_SLEEPING && edge_c && armed[2]) |=> !asleep && flag_ff[2];
  endproperty
  a_c_wake: assert property (p_c_wake) else $error("edge on c did not wake");

  property p_wake_pulse;
    @(posedge sys_clk) disable iff (reset)
    $fell(asleep) |-> wake ##1 !wake;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse missing");

  property p_c_only_edge;
    @(posedge sys_clk) disable iff (reset)
    irq_pending[2] |-> flag_ff[2];
  endproperty
  a_c_only_edge: assert property (p_c_only_edge) else $error("line c level request");

  property p_startup_block;
    @(posedge sys_clk) disable iff (reset)
    (state_ff == ST_STARTUP) |-> lvl_req == 2'h0;
  endproperty
  a_startup_block: assert property (p_startup_block) else $error("level request in start-up");

  property p_ack_clear;
    @(posedge sys_clk) disable iff (reset)
    (irq_ack[0] && !events[0]) |=> !flag_ff[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("handler entry kept flag a");

  property p_any_change;
    @(posedge sys_clk) disable iff (reset)
    (sense_a_ff == SENSE_ANY) && io_run && (ab_prev_ff[0] != pin_s2_ff[0]) |=> flag_ff[0];
  endproperty
  a_any_change: assert property (p_any_change) else $error("change on a not flagged");

endmodule

//--- rtl/ext_irq_pkg.sv
// Behaviour
// - pin activity raises enabled interrupts even when the pin is driven as output
// - lines trigger on falling edge, rising edge or low level per config
// - line c is edge only; level sensing exists on lines a and b
// - enabled level line keeps requesting while the pin stays low; the code drops the request in the qualification and start-up states
// - edges on lines a and b are seen only while the io clock runs
// - low levels on a/b and edges on c are seen in every sleep mode
// - io clock stops in all sleep modes except idle
// - power-down level wake needs two watchdog samples one period apart
// - level gone before start-up end: wake anyway, but no level interrupt
// - a/b sense field: 00 low, 01 any change, 10 falling, 11 rising
// - c polarity: 0 falling, 1 rising; changing it may raise an event
// - flag set by edge, cleared by handler or write one; zero in level mode
// - service needs the global enable and the line enable
package ext_irq_pkg;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } sense_t;

  typedef enum logic [1:0] {
    MODE_IDLE       = 2'b00,
    MODE_NOISE_RED  = 2'b01,
    MODE_POWER_SAVE = 2'b10,
    MODE_POWER_DOWN = 2'b11
  } sleep_mode_t;

  typedef enum logic [2:0] {
    ST_AWAKE    = 3'b000,
    ST_SLEEPING = 3'b001,
    ST_QUAL1    = 3'b010,
    ST_QUAL2    = 3'b011,
    ST_STARTUP  = 3'b100
  } wake_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CSR    = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_FLAG   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_SLEEP  = 8'h14;

  // field positions
  localparam int SENSE_A_LSB  = 0;
  localparam int SENSE_B_LSB  = 2;
  localparam int POL_C_BIT    = 6;
  localparam int LINE_B_BIT   = 7;
  localparam int LINE_A_BIT   = 6;
  localparam int LINE_C_BIT   = 5;
  localparam int GLOBAL_BIT   = 7;
  localparam int SLEEP_GO_BIT = 0;
  localparam int SLEEP_MODE_LSB = 1;
  localparam int PIN_VIEW_LSB = 4;
  localparam int STATE_LSB    = 8;

  // reset values
  localparam logic [1:0] SENSE_RST = 2'h0;
  localparam logic [2:0] LINES_RST = 3'h0;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int WDT_PERIOD_NS = 1000;
  localparam int WDT_CYC = (WDT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC_DEF = 64;

endpackage

//--- tb/pin_source.sv
module pin_source (
  // clock
  input  wire logic       sys_clk,
  // levels asked for by the bench
  input  wire logic [2:0] want,
  // pads, bit0 line a, bit1 line b, bit2 line c
  output logic      [2:0] irq_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // pads follow the asked level one edge late and idle high; a level stays until
  // the bench asks for another, so a wake level is held through both samples
  // and the start-up delay only in the level wake run; the short pulse and late release runs drop it early
  always @(posedge sys_clk) irq_pin <= want;
endmodule

//--- tb/tb_external_pin_interrupt_unit.sv
module tb_external_pin_interrupt_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import ext_irq_pkg::*;

  // short start-up delay keeps the power-down runs brief
  localparam int unsigned SU = 16;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  apb_req_t    apb_req = '0;
  apb_rsp_t    apb_rsp;
  logic [2:0]  want = 3'h7;
  logic [2:0]  irq_pin;
  logic [2:0]  irq_ack = 3'h0;
  logic [2:0]  irq_pending;
  logic        irq;
  logic        asleep;
  logic        io_clk_run;
  logic        wake;
  int          n_errors = 0;
  int          n_tests = 0;
  int          seed = 32'h59DC8E43;
  int          k;
  logic [31:0] rd;
  logic        err;
  logic [2:0]  o, n, ef, arm;
  logic [1:0]  sa, sb;
  logic        pc, g;
  logic [7:0]  en;

  // clock and the far-side pad source
  always #50 sys_clk = ~sys_clk;
  pin_source i_src (.sys_clk(sys_clk), .want(want), .irq_pin(irq_pin));
  ext_irq_unit #(.STARTUP_CYC(SU)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .irq_pin(irq_pin), .irq_ack(irq_ack), .irq(irq), .irq_pending(irq_pending),
    .asleep(asleep), .io_clk_run(io_clk_run), .wake(wake));

  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    @(posedge sys_clk);
    while (apb_rsp.pready !== 1'b1) @(posedge sys_clk);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded wait for the sequencer to come back
  task automatic wait_awake();
    for (int j = 0; j < 120 && asleep !== 1'b0; j++) @(posedge sys_clk);
  endtask

  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // expected edge hit for a/b sense fields
  function automatic logic edge_hit(input logic [1:0] s, input logic a, input logic b);
    case (s)
      SENSE_ANY:  return a ^ b;
      SENSE_FALL: return a & ~b;
      SENSE_RISE: return ~a & b;
      default:    return 1'b0;
    endcase
  endfunction

  // watchdog: the whole sequence needs about a thousand cycles
  initial
  begin
    cyc(20000);
    n_errors++;
    end_sim();
  end

  // main sequence
  initial
  begin
    cyc(4);
    reset <= 1'b0;
    for (k = 0; k < 5; k++)
    begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk("reg reset", rd, 32'h0);
    end
    apb(1'b0, OFS_SLEEP, 32'h0);
    chk("sleep reset", rd, 32'h70);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    chk("irq reset", {irq, asleep, io_clk_run}, 3'b001);
    $display("test reset done");
    // random configurations and pad transitions
    for (int i = 0; i < 24; i++)
    begin
      o = 3'($random(seed));
      n = 3'($random(seed));
      sa = 2'(32'd1 + {$random(seed)} % 3);
      sb = 2'(32'd1 + {$random(seed)} % 3);
      pc = 1'($random(seed));
      g = 1'($random(seed));
      en = 8'($random(seed)) & 8'hE0;
      want <= o;
      cyc(4);
      apb(1'b1, OFS_CTRL, {28'h0, sb, sa});
      apb(1'b1, OFS_CSR, 32'(pc) << POL_C_BIT);
      apb(1'b1, OFS_ENABLE, {24'h0, en});
      apb(1'b1, OFS_STATUS, 32'(g) << GLOBAL_BIT);
      apb(1'b1, OFS_FLAG, 32'hE0);
      want <= n;
      cyc(5);
      ef = {pc ? (~o[2] & n[2]) : (o[2] & ~n[2]),
            edge_hit(sb, o[1], n[1]), edge_hit(sa, o[0], n[0])};
      arm = {en[5], en[7], en[6]} & {3{g}};
      chk("pending", irq_pending, ef & arm);
      chk("irq", irq, g & |({ef[1], ef[0], ef[2]} & en[7:5]));
      apb(1'b0, OFS_FLAG, 32'h0);
      chk("flag reg", rd, 32'({ef[1], ef[0], ef[2]}) << 5);
      if (i[0])
        apb(1'b1, OFS_FLAG, 32'hE0);
      else
      begin
        irq_ack <= 3'h7;
        cyc(1);
        irq_ack <= 3'h0;
      end
      cyc(2);
      chk("cleared", irq_pending, 3'h0);
    end
    $display("test random edges done");
    // level mode on line a
    want <= 3'h7;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_ENABLE, 32'h40);
    apb(1'b1, OFS_STATUS, 32'h80);
    apb(1'b1, OFS_FLAG, 32'hE0);
    want <= 3'h6;
    cyc(5);
    for (k = 0; k < 8; k++)
    begin
      chk("level irq", irq, 1'b1);
      cyc(1);
    end
    apb(1'b0, OFS_FLAG, 32'h0);
    chk("level flag", rd, 32'h0);
    want <= 3'h7;
    cyc(5);
    chk("level off", irq, 1'b0);
    $display("test level done");
    // power-down: a/b edges lost, edge on c wakes
    apb(1'b1, OFS_CTRL, 32'hA);
    apb(1'b1, OFS_CSR, 32'h0);
    apb(1'b1, OFS_ENABLE, 32'hE0);
    apb(1'b1, OFS_FLAG, 32'hE0);
    apb(1'b1, OFS_SLEEP, 32'h7);
    cyc(2);
    chk("pd state", {asleep, io_clk_run}, 2'b10);
    want <= 3'h4;
    cyc(6);
    chk("pd ab lost", {asleep, irq_pending}, 4'b1000);
    want <= 3'h0;
    wait_awake();
    chk("c wakes", {asleep, wake, irq_pending}, 5'b01100);
    // idle keeps the io clock, so an edge on a is caught
    want <= 3'h7;
    cyc(4);
    apb(1'b1, OFS_FLAG, 32'hE0);
    apb(1'b1, OFS_SLEEP, 32'h1);
    cyc(2);
    chk("idle state", {asleep, io_clk_run}, 2'b11);
    want <= 3'h6;
    wait_awake();
    chk("idle edge", {asleep, wake, irq_pending[0]}, 3'b011);
    $display("test sleep edges done");
    // power-down level wake: short pulse refused, held level wakes
    want <= 3'h7;
    cyc(4);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_ENABLE, 32'h40);
    apb(1'b1, OFS_SLEEP, 32'h7);
    want <= 3'h6;
    cyc(5);
    want <= 3'h7;
    cyc(40);
    chk("short pulse", asleep, 1'b1);
    want <= 3'h6;
    cyc(15);
    chk("qualifying", asleep, 1'b1);
    wait_awake();
    chk("level wake", {asleep, wake, irq}, 3'b011);
    // level gone during start-up: wake without a request
    want <= 3'h7;
    cyc(4);
    apb(1'b1, OFS_SLEEP, 32'h7);
    want <= 3'h6;
    cyc(27);
    want <= 3'h7;
    wait_awake();
    cyc(3);
    chk("late release", {asleep, wake, irq}, 3'b000);
    $display("test level wake done");
    end_sim();
  end
endmodule
